// File: verilog/sprb_bank.v
// Indirectly addressed sensor parameter bank with result routing.
//
// How it works
// (R01) Parameters reachable only through query/set commands
// (R02) Bus address changes on address command
// (R03) Channel list enables bits seven to four
// (R04) UV and auxiliary share auxiliary result pair
// (R05) Infrared and visible results to own pairs
// (R06) Host writes non-zero channel list first
// (R07) Bit five aligns visible conversion
// (R08) Bit four aligns infrared conversion
// (R09) Infrared input select, zero is small diode
// (R10) Host keeps reserved locations at default
// (R11) Auxiliary select: temperature or supply voltage
// (R12) Gain lengthens integration by two power
// (R13) Recovery code gives scaled converter clocks
// (R14) Range bit selects high signal range
`timescale 1ns/1ps
`default_nettype none
`include "sprb_regs.vh"

module sprb_bank
#(
  // Address answered after reset; the value is arbitrary.
  parameter [7:0] START_BUS_ADDRESS = 8'h00
)
(
  // Clock and reset
  input  wire        clk,
  input  wire        nrst,
  // Command port
  input  wire        cmd_valid,
  input  wire [1:0]  cmd_code,
  input  wire [5:0]  cmd_offset,
  input  wire [7:0]  cmd_data,
  output reg         cmd_done,
  output reg  [7:0]  param_read_data,
  // Bus address in force
  output reg  [7:0]  bus_address,
  // Conversion inputs
  input  wire        visible_valid,
  input  wire [16:0] visible_conversion,
  input  wire        infrared_valid,
  input  wire [16:0] infrared_conversion,
  input  wire        uv_valid,
  input  wire [15:0] uv_conversion,
  input  wire        auxiliary_valid,
  input  wire [15:0] auxiliary_conversion,
  // Result pairs
  output reg  [7:0]  visible_result_high,
  output reg  [7:0]  visible_result_low,
  output reg  [7:0]  infrared_result_high,
  output reg  [7:0]  infrared_result_low,
  output reg  [7:0]  auxiliary_result_high,
  output reg  [7:0]  auxiliary_result_low,
  // Converter settings
  output wire [3:0]  channel_enables,
  output wire [7:0]  infrared_input_select,
  output wire [7:0]  auxiliary_input_select,
  output wire        aux_is_temperature,
  output wire        aux_is_supply,
  output wire        ir_small_diode,
  output wire [7:0]  visible_gain_factor,
  output wire [7:0]  infrared_gain_factor,
  output wire [15:0] visible_recovery_clocks,
  output wire [15:0] infrared_recovery_clocks,
  output wire        visible_high_range,
  output wire        infrared_high_range
);

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  reg        rst_sync_a_n;
  reg        rst_n;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_sync_a_n <= 1'b0;
      rst_n        <= 1'b0;
    end
    else
    begin
      rst_sync_a_n <= 1'b1;
      rst_n        <= rst_sync_a_n;
    end
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function [7:0] reset_value;
    input [4:0] index;
    begin
      case (index)
        `SPRB_RESERVED_0D:            reset_value = `SPRB_RESERVED_0D_RESET;
        `SPRB_AUXILIARY_INPUT_SELECT: reset_value = `SPRB_AUX_SELECT_RESET;
        `SPRB_VISIBLE_RECOVERY_COUNT: reset_value = `SPRB_RECOVERY_RESET;
        `SPRB_RESERVED_13:            reset_value = `SPRB_RESERVED_13_RESET;
        `SPRB_INFRARED_RECOVERY_COUNT: reset_value = `SPRB_RECOVERY_RESET;
        default:                      reset_value = `SPRB_ZERO_RESET;
      endcase
    end
  endfunction

  // Two raised to the 3-bit gain code, 1 to 128.
  function [7:0] gain_factor;
    input [2:0] code;
    begin
      gain_factor = 8'h01 << code;
    end
  endfunction

  // Recovery clocks 1,7,15,...,511, lengthened by the gain factor.
  function [15:0] recovery_clocks;
    input [2:0] rec;
    input [2:0] gain;
    reg   [9:0] base;
    begin
      base = 10'h001;
      if (rec != 3'h0)
        base = (10'h004 << rec) - 10'h001;
      recovery_clocks = {6'h00, base} << gain;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Parameter storage
  // --------------------------------------------------------------------------
  // Reserved locations are stored as written so that a query returns what
  // the host put there; the bank does not police them.
  reg  [7:0] param_mem [0:31];
  wire       in_range = (cmd_offset <= `SPRB_LAST_LOCATION);
  wire       do_read  = cmd_valid && (cmd_code == `SPRB_CMD_READ);
  wire       do_write = cmd_valid && (cmd_code == `SPRB_CMD_WRITE);
  wire       do_addr  = cmd_valid && (cmd_code == `SPRB_CMD_BUS_ADDRESS);
  integer    i;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < 32; i = i + 1)
        param_mem[i] <= reset_value(i[4:0]);
    end
    else if (do_write && in_range) // R01
      param_mem[cmd_offset[4:0]] <= cmd_data;
  end

  // --------------------------------------------------------------------------
  // Command answers
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_done        <= 1'b0;
      param_read_data <= 8'h00;
      bus_address     <= START_BUS_ADDRESS;
    end
    else
    begin
      cmd_done <= cmd_valid;
      if (do_read) // R01
        param_read_data <= in_range ? param_mem[cmd_offset[4:0]] : 8'h00;
      if (do_addr) // R02
        bus_address <= param_mem[`SPRB_BUS_ADDRESS_NEXT];
    end
  end

  // --------------------------------------------------------------------------
  // Settings decode
  // --------------------------------------------------------------------------
  wire [7:0] enlist = param_mem[`SPRB_CHANNEL_ENABLE_LIST];
  wire [7:0] align  = param_mem[`SPRB_RESULT_ALIGNMENT];
  wire [7:0] vgain  = param_mem[`SPRB_VISIBLE_GAIN];
  wire [7:0] igain  = param_mem[`SPRB_INFRARED_GAIN];
  wire [7:0] vrec   = param_mem[`SPRB_VISIBLE_RECOVERY_COUNT];
  wire [7:0] irec   = param_mem[`SPRB_INFRARED_RECOVERY_COUNT];

  assign channel_enables        = enlist[7:4]; // R03
  assign infrared_input_select  = param_mem[`SPRB_INFRARED_INPUT_SELECT];
  assign ir_small_diode         =
    (infrared_input_select == `SPRB_IR_SMALL_DIODE); // R09
  assign auxiliary_input_select = param_mem[`SPRB_AUXILIARY_INPUT_SELECT];
  assign aux_is_temperature     =
    (auxiliary_input_select == `SPRB_AUX_TEMPERATURE); // R11
  assign aux_is_supply          =
    (auxiliary_input_select == `SPRB_AUX_SUPPLY); // R11
  assign visible_gain_factor    =
    gain_factor(vgain[`SPRB_GAIN_MSB:0]); // R12
  assign infrared_gain_factor   = gain_factor(igain[`SPRB_GAIN_MSB:0]);
  assign visible_recovery_clocks = recovery_clocks(
    vrec[`SPRB_RECOVERY_MSB:`SPRB_RECOVERY_LSB],
    vgain[`SPRB_GAIN_MSB:0]); // R13
  assign infrared_recovery_clocks = recovery_clocks(
    irec[`SPRB_RECOVERY_MSB:`SPRB_RECOVERY_LSB],
    igain[`SPRB_GAIN_MSB:0]);
  assign visible_high_range     =
    param_mem[`SPRB_VISIBLE_RANGE_MISC][`SPRB_HIGH_RANGE_BIT]; // R14
  assign infrared_high_range    =
    param_mem[`SPRB_INFRARED_RANGE_MISC][`SPRB_HIGH_RANGE_BIT];

  // --------------------------------------------------------------------------
  // Result alignment
  // --------------------------------------------------------------------------
  wire [15:0] visible_word;
  wire [15:0] infrared_word;

  sprb_align u_visible_align
  (
    .conversion (visible_conversion),
    .take_low   (align[`SPRB_ALIGNMENT_BIT_FIVE]), // R07
    .reported   (visible_word)
  );

  sprb_align u_infrared_align
  (
    .conversion (infrared_conversion),
    .take_low   (align[`SPRB_ALIGNMENT_BIT_FOUR]), // R08
    .reported   (infrared_word)
  );

  // --------------------------------------------------------------------------
  // Result pairs
  // --------------------------------------------------------------------------
  // A conversion for a disabled channel is dropped. With the list still
  // zero nothing is ever stored, which is why software must fill it first.
  wire uv_take  = uv_valid && enlist[`SPRB_UV_INDEX_ENABLE_BIT]; // R06
  wire aux_take = auxiliary_valid && enlist[`SPRB_AUXILIARY_ENABLE_BIT];

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      visible_result_high   <= 8'h00;
      visible_result_low    <= 8'h00;
      infrared_result_high  <= 8'h00;
      infrared_result_low   <= 8'h00;
      auxiliary_result_high <= 8'h00;
      auxiliary_result_low  <= 8'h00;
    end
    else
    begin
      if (visible_valid && enlist[`SPRB_VISIBLE_ENABLE_BIT]) // R05
      begin
        visible_result_high <= visible_word[15:8];
        visible_result_low  <= visible_word[7:0];
      end
      if (infrared_valid && enlist[`SPRB_INFRARED_ENABLE_BIT]) // R05
      begin
        infrared_result_high <= infrared_word[15:8];
        infrared_result_low  <= infrared_word[7:0];
      end
      // Both sources share one pair; the UV index wins a same-cycle tie.
      if (uv_take) // R04
      begin
        auxiliary_result_high <= uv_conversion[15:8];
        auxiliary_result_low  <= uv_conversion[7:0];
      end
      else if (aux_take) // R04
      begin
        auxiliary_result_high <= auxiliary_conversion[15:8];
        auxiliary_result_low  <= auxiliary_conversion[7:0];
      end
    end
  end

endmodule

`default_nettype wire

// File: pkg/sprb_regs.vh
// Offsets, fields, reset values and command codes of the parameter bank.
`ifndef SPRB_REGS_VH
`define SPRB_REGS_VH

// ----------------------------------------------------------------------------
// Parameter locations
// ----------------------------------------------------------------------------
`define SPRB_BUS_ADDRESS_NEXT        5'h00
`define SPRB_CHANNEL_ENABLE_LIST     5'h01
`define SPRB_RESULT_ALIGNMENT        5'h06
`define SPRB_RESERVED_0D             5'h0d
`define SPRB_INFRARED_INPUT_SELECT   5'h0e
`define SPRB_AUXILIARY_INPUT_SELECT  5'h0f
`define SPRB_VISIBLE_RECOVERY_COUNT  5'h10
`define SPRB_VISIBLE_GAIN            5'h11
`define SPRB_VISIBLE_RANGE_MISC      5'h12
`define SPRB_RESERVED_13             5'h13
`define SPRB_INFRARED_RECOVERY_COUNT 5'h1d
`define SPRB_INFRARED_GAIN           5'h1e
`define SPRB_INFRARED_RANGE_MISC     5'h1f
`define SPRB_LAST_LOCATION           6'h1f

// ----------------------------------------------------------------------------
// Reset values: the zero default and those that are not zero
// ----------------------------------------------------------------------------
`define SPRB_ZERO_RESET              8'h00
`define SPRB_RESERVED_0D_RESET       8'h02
`define SPRB_AUX_SELECT_RESET        8'h65
`define SPRB_RECOVERY_RESET          8'h70
`define SPRB_RESERVED_13_RESET       8'h40

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SPRB_UV_INDEX_ENABLE_BIT     7
`define SPRB_AUXILIARY_ENABLE_BIT    6
`define SPRB_INFRARED_ENABLE_BIT     5
`define SPRB_VISIBLE_ENABLE_BIT      4
`define SPRB_ALIGNMENT_BIT_FIVE      5
`define SPRB_ALIGNMENT_BIT_FOUR      4
`define SPRB_RECOVERY_MSB            6
`define SPRB_RECOVERY_LSB            4
`define SPRB_GAIN_MSB                2
`define SPRB_HIGH_RANGE_BIT          5

// ----------------------------------------------------------------------------
// Auxiliary source codes and infrared input select code
// ----------------------------------------------------------------------------
`define SPRB_AUX_TEMPERATURE         8'h65
`define SPRB_AUX_SUPPLY              8'h75
`define SPRB_IR_SMALL_DIODE          8'h00

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define SPRB_CMD_READ                2'h1
`define SPRB_CMD_WRITE               2'h2
`define SPRB_CMD_BUS_ADDRESS         2'h3

`endif

// File: verilog/sprb_align.v
// Picks the reported 16 bits out of a 17-bit conversion result.
`timescale 1ns/1ps
`default_nettype none

module sprb_align
(
  // Conversion in
  input  wire [16:0] conversion,
  input  wire        take_low,
  // Reported word
  output wire [15:0] reported
);

  assign reported = take_low ? conversion[15:0] : conversion[16:1];

endmodule

`default_nettype wire

// File: testbench/sprb_monitor.sv
// Port checker of the parameter bank.
`timescale 1ns/1ps
`default_nettype none
module sprb_monitor
(
  input wire        clk,
  input wire        nrst,
  input wire        cmd_valid,
  input wire [1:0]  cmd_code,
  input wire [5:0]  cmd_offset,
  input wire [7:0]  cmd_data,
  input wire        cmd_done,
  input wire [7:0]  bus_address,
  input wire        visible_valid,
  input wire        uv_valid,
  input wire [15:0] uv_conversion,
  input wire        auxiliary_valid,
  input wire [15:0] auxiliary_conversion,
  input wire [7:0]  visible_result_high,
  input wire [7:0]  visible_result_low,
  input wire [7:0]  auxiliary_result_high,
  input wire [7:0]  auxiliary_result_low,
  input wire [3:0]  channel_enables,
  input wire [7:0]  auxiliary_input_select,
  input wire        aux_is_temperature,
  input wire        aux_is_supply
);
  wire [15:0] aux_word = {auxiliary_result_high, auxiliary_result_low};
  wire        uv_on = uv_valid && channel_enables[3];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_DONE:
    assert property (cmd_valid |=> cmd_done) else $error("no done");
  AST_NO_DONE:
    assert property (!cmd_valid |=> !cmd_done) else $error("stray done");
  AST_ADDR:
    assert property ($changed(bus_address) |->
      $past(cmd_valid) && $past(cmd_code) == 2'h3) else $error("addr moved");
  AST_LIST:
    assert property (cmd_valid && cmd_code == 2'h2 && cmd_offset == 6'h01
      |=> channel_enables == $past(cmd_data[7:4])) else $error("bad list");
  AST_VIS_HOLD:
    assert property (!(visible_valid && channel_enables[0]) |=>
      $stable({visible_result_high, visible_result_low}))
    else $error("vis moved");
  AST_UV:
    assert property (uv_on |=> aux_word == $past(uv_conversion))
    else $error("bad uv");
  AST_AUX:
    assert property (auxiliary_valid && channel_enables[2] && !uv_on |=>
      aux_word == $past(auxiliary_conversion)) else $error("bad aux");
  AST_SOURCE:
    assert property (aux_is_supply == (auxiliary_input_select == 8'h75) &&
      aux_is_temperature == (auxiliary_input_select == 8'h65))
    else $error("bad source");
  cover property (uv_on && auxiliary_valid);
  cover property (cmd_valid && cmd_code == 2'h3);
  cover property (cmd_valid && cmd_code == 2'h1);
endmodule
bind sprb_bank sprb_monitor i_mon (.*);
`default_nettype wire

// File: testbench/sprb_host.sv
// Host model that issues parameter commands.
`timescale 1ns/1ps
`default_nettype none
module sprb_host
(
  input wire         clk,
  input wire         cmd_done,
  output logic       cmd_valid = 1'b0,
  output logic [1:0] cmd_code = 2'h0,
  output logic [5:0] cmd_offset = 6'h00,
  output logic [7:0] cmd_data = 8'h00
);
  // Data is inverted once released, so a late sample cannot pass.
  task automatic send(input logic [1:0] c, input logic [5:0] o,
    input logic [7:0] d, output logic ok);
  begin
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_offset = o;
    cmd_data = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_data = ~d;
    ok = cmd_done;
  end
  endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench of the parameter bank.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, nrst = 1'b0, ok;
  logic visible_valid = 1'b0, infrared_valid = 1'b0;
  logic uv_valid = 1'b0, auxiliary_valid = 1'b0;
  logic [16:0] visible_conversion = 17'h0_0000;
  logic [16:0] infrared_conversion = 17'h0_0000;
  logic [15:0] uv_conversion = 16'h0000, auxiliary_conversion = 16'h0000;
  logic [15:0] xv = 16'h0000, xi = 16'h0000, xa = 16'h0000;
  logic [15:0] xg;
  logic [7:0] d;
  logic [3:0] en;
  wire cmd_valid, cmd_done, aux_is_temperature, aux_is_supply, ir_small_diode;
  wire visible_high_range, infrared_high_range;
  wire [1:0] cmd_code;
  wire [5:0] cmd_offset;
  wire [3:0] channel_enables;
  wire [7:0] cmd_data, param_read_data, bus_address, visible_result_high;
  wire [7:0] visible_result_low, infrared_result_high, infrared_result_low;
  wire [7:0] auxiliary_result_high, auxiliary_result_low, infrared_input_select;
  wire [7:0] auxiliary_input_select, visible_gain_factor, infrared_gain_factor;
  wire [15:0] visible_recovery_clocks, infrared_recovery_clocks;
  int n_tests = 0, n_mismatch = 0, cycles = 0;
  localparam logic [5:0] OFS [11] = '{6'h00, 6'h01, 6'h06, 6'h0e, 6'h0f,
    6'h10, 6'h11, 6'h12, 6'h1d, 6'h1e, 6'h1f};
  localparam logic [7:0] RST [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h65,
    8'h70, 8'h00, 8'h00, 8'h70, 8'h00, 8'h00};
  localparam logic [7:0] MSK [11] = '{8'hff, 8'hf0, 8'h30, 8'hff, 8'hff,
    8'h70, 8'h07, 8'h20, 8'h70, 8'h07, 8'h20};
  sprb_bank i_dut (.*);
  sprb_host i_host (.*);
  always #2.5 clk = ~clk;
  function automatic logic [15:0] align(input logic [16:0] c, input logic lo);
    return lo ? c[15:0] : c[16:1];
  endfunction
  function automatic logic [15:0] rec(input logic [2:0] r, input int g);
    return (r == 3'h0 ? 16'h0001 : (16'h0004 << r) - 16'h0001) << g;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
  begin
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  end
  endtask
  task automatic cmd(input logic [1:0] c, input logic [5:0] o,
    input logic [7:0] v);
  begin
    i_host.send(c, o, v, ok);
    chk(ok, 1'b1);
  end
  endtask
  task automatic rd(input logic [5:0] o, input logic [7:0] e);
  begin
    cmd(2'h1, o, 8'h00);
    chk(param_read_data, e);
  end
  endtask
  // Valid strobes rise together, uv only when both is set, so the uv and auxiliary clash is exercised.
  task automatic conv(input logic both, input logic [1:0] a);
  begin
    @(negedge clk);
    visible_conversion = 17'($urandom);
    infrared_conversion = 17'($urandom);
    uv_conversion = 16'($urandom);
    auxiliary_conversion = 16'($urandom);
    {visible_valid, infrared_valid, auxiliary_valid, uv_valid} = {3'h7, both};
    @(negedge clk);
    {visible_valid, infrared_valid, auxiliary_valid, uv_valid} = 4'h0;
    if (en[0]) xv = align(visible_conversion, a[1]);
    if (en[1]) xi = align(infrared_conversion, a[0]);
    if (en[2]) xa = auxiliary_conversion;
    if (en[3] && both) xa = uv_conversion;
    chk({visible_result_high, visible_result_low}, xv);
    chk({infrared_result_high, infrared_result_low}, xi);
    chk({auxiliary_result_high, auxiliary_result_low}, xa);
  end
  endtask
  task automatic end_of_test;
  begin
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_mismatch++;
      end_of_test;
    end
  end
  initial
  begin
    void'($urandom(12994));
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 11; i++)
      rd(OFS[i], RST[i]);
    chk(visible_recovery_clocks, 16'h01ff);
    chk({aux_is_temperature, ir_small_diode}, 2'h3);
    for (int i = 0; i < 11; i++)
    begin
      d = 8'($urandom) & MSK[i];
      cmd(2'h2, OFS[i], d);
      rd(OFS[i], d);
    end
    rd(6'h2a, 8'h00);
    $display("registers done");
    for (int g = 0; g < 8; g++)
    begin
      d = {1'b0, 3'($urandom), 4'h0};
      cmd(2'h2, 6'h11, 8'(g));
      cmd(2'h2, 6'h10, d);
      cmd(2'h2, 6'h1e, 8'(7 - g));
      cmd(2'h2, 6'h1d, d);
      xg = {8'h01 << g, 8'h80 >> g};
      chk({visible_gain_factor, infrared_gain_factor}, xg);
      chk(visible_recovery_clocks, rec(d[6:4], g));
      chk(infrared_recovery_clocks, rec(d[6:4], 7 - g));
    end
    cmd(2'h2, 6'h12, 8'h20);
    cmd(2'h2, 6'h1f, 8'h00);
    chk({visible_high_range, infrared_high_range}, 2'h2);
    d = 8'($urandom_range(255, 1));
    cmd(2'h2, 6'h00, d);
    chk(bus_address, 8'h00);
    cmd(2'h3, 6'h00, 8'h00);
    chk(bus_address, d);
    cmd(2'h0, 6'h00, ~d);
    rd(6'h00, d);
    cmd(2'h2, 6'h2a, 8'h5a);
    rd(6'h0a, 8'h00);
    cmd(2'h2, 6'h0f, 8'h75);
    cmd(2'h2, 6'h0e, 8'h01);
    chk({aux_is_supply, aux_is_temperature, ir_small_diode}, 3'h4);
    chk({auxiliary_input_select, infrared_input_select}, 16'h7501);
    $display("settings done");
    for (int k = 0; k < 12; k++)
    begin
      en = (k == 0) ? 4'h1 : 4'($urandom_range(15, 1));
      cmd(2'h2, 6'h06, {2'h0, 2'(k), 4'h0});
      cmd(2'h2, 6'h01, {en, 4'h0});
      chk(channel_enables, en);
      conv(k[2], 2'(k));
    end
    $display("results done");
    end_of_test;
  end
endmodule
`default_nettype wire
